// file: common/a429c_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * serial interface control block.
 * Assumes inclusion by bare name from the block's modules only.
 */
`ifndef A429C_CFG_SVH
`define A429C_CFG_SVH

// config word as captured from host bus lines 15..5
`define A429C_CFG_W        11
`define A429C_CFG_BUS_LSB  5
`define A429C_CFG_RESET    11'h001
`define A429C_F_SELFTEST_N 0
`define A429C_F_R1_EN      1
`define A429C_F_R1_A       2
`define A429C_F_R1_B       3
`define A429C_F_PAR_FLIP   7
`define A429C_F_TX_RATE    8
`define A429C_F_RX_RATE    9
`define A429C_F_LEN        10

// clock divisors for the two bit rates
`define A429C_DIV_FAST     10
`define A429C_DIV_SLOW     80
// null bits between words, idle bit times before a partial word is dropped
`define A429C_GAP_BITS     4
`define A429C_RX_TMO_BITS  2
// serial word lengths
`define A429C_LEN_LONG     32
`define A429C_LEN_SHORT    25

`endif

// file: common/a429c_pkg.sv
/*
 * Types of the serial interface control block.
 * Assumes nothing of its surroundings.
 */
package a429c_pkg;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_BITS = 3'b010,
        TX_GAP  = 3'b100
    } a429c_tx_state_t;

    typedef logic [10:0] a429c_cfg_t;

endpackage : a429c_pkg

// file: rtl/a429c_fifo.sv
/*
 * Transmit word FIFO, valid/ready on both sides, synchronous clear.
 * Assumes one clock; hold blocks writes one cycle after it rises.
 */
`timescale 1ns/1ns
module a429c_fifo #(
    parameter int W  = 31,
    parameter int D  = 8,
    parameter int AW = 3
) (
    // clock and clear
    input  wire logic         clk,
    input  wire logic         clr,
    input  wire logic         hold,
    // fill side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // drain side
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic              empty
);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0]   next_count;
    logic          next_in_ready;
    logic          wr;
    logic          rd;

    always_comb begin
        wr            = in_valid && in_ready;
        rd            = out_ready && out_valid;
        next_wr_ptr   = wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr   = rd ? rd_ptr + 1'b1 : rd_ptr;
        next_count    = count + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
        next_in_ready = (next_count < (AW+1)'(D)) && !hold;
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            in_ready <= 1'b0;
        end else begin
            wr_ptr   <= next_wr_ptr;
            rd_ptr   <= next_rd_ptr;
            count    <= next_count;
            in_ready <= next_in_ready;
        end
        if (wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    assign out_data  = mem[rd_ptr];
    assign out_valid = (count != '0);
    assign empty     = (count == '0);

endmodule : a429c_fifo

// file: rtl/a429c_rate_div.sv
/*
 * Bit-rate divider: tick at each bit start, half at mid-bit, clock out.
 * Assumes the rate select changes only between words.
 */
`timescale 1ns/1ns
`include "a429c_cfg.svh"
module a429c_rate_div #(
    parameter int FAST = `A429C_DIV_FAST,
    parameter int SLOW = `A429C_DIV_SLOW,
    parameter int CW   = 7
) (
    // clock and clear
    input  wire logic clk,
    input  wire logic clr,
    // rate select, 1 = slow
    input  wire logic slow,
    // timing outputs
    output logic      tick,
    output logic      half,
    output logic      clk_out
);
    localparam logic [CW-1:0] F_TOP  = CW'(FAST - 1);
    localparam logic [CW-1:0] S_TOP  = CW'(SLOW - 1);
    localparam logic [CW-1:0] F_HALF = CW'(FAST / 2);
    localparam logic [CW-1:0] S_HALF = CW'(SLOW / 2);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [CW-1:0] top;
    logic [CW-1:0] mid;
    logic          next_tick;
    logic          next_half;
    logic          next_clk_out;

    always_comb begin
        top          = slow ? S_TOP : F_TOP;
        mid          = slow ? S_HALF : F_HALF;
        next_tick    = (cnt >= top);
        next_cnt     = next_tick ? '0 : cnt + 1'b1;
        next_half    = (next_cnt == mid);
        next_clk_out = (next_cnt < mid);
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            cnt     <= '0;
            tick    <= 1'b0;
            half    <= 1'b0;
            clk_out <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            tick    <= next_tick;
            half    <= next_half;
            clk_out <= next_clk_out;
        end
    end

endmodule : a429c_rate_div

// file: rtl/a429c_top.sv
/*
 * Control word register, transmitter and two filtering receivers.
 * Assumes pins are asynchronous to clk and the word source is on clk.
 */
`timescale 1ns/1ns
`include "a429c_cfg.svh"
module a429c_top
    import a429c_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int TMO_W = 8
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // host pins
    input  wire logic        master_clear_n,
    input  wire logic        config_strobe,
    input  wire logic        transmit_go,
    input  wire logic [15:0] host_bus_line,
    // transmit word stream, bits 30..0 of a long serial word, bits 23..0 of a short one
    input  wire logic [30:0] tx_word_data,
    input  wire logic        tx_word_valid,
    output logic             tx_word_ready,
    // receiver line pins, one per receiver
    input  wire logic [1:0]  rx_line_a,
    input  wire logic [1:0]  rx_line_b,
    // transmitter pins
    output logic             line_out_hi,
    output logic             line_out_lo,
    output logic             send_bit_clock_out,
    output logic             tx_empty,
    output a429c_cfg_t       config_word,
    // received words
    output logic [31:0]      rcv1_word,
    output logic             rcv1_ready,
    output logic [31:0]      rcv2_word,
    output logic             rcv2_ready
);
    ////////////////////////////////////////////////////////////////////////
    localparam int SW  = 23;
    localparam int MC  = 16, STB = 17, GO = 18, RXA = 19, RXB = 21;
    localparam logic [SW-1:0] SYNC_RST = 23'h010000;
    localparam logic [5:0] LEN_L = 6'(`A429C_LEN_LONG);
    localparam logic [5:0] LEN_S = 6'(`A429C_LEN_SHORT);
    localparam logic [2:0] GAP_END = 3'(`A429C_GAP_BITS - 1);
    localparam logic [TMO_W-1:0] TMO_F = TMO_W'(`A429C_DIV_FAST * `A429C_RX_TMO_BITS);
    localparam logic [TMO_W-1:0] TMO_S = TMO_W'(`A429C_DIV_SLOW * `A429C_RX_TMO_BITS);
    logic [SW-1:0] s1, s2, s3, f, f_q, next_f;
    logic          strobe_rise, go, clr;
    a429c_cfg_t    next_cfg;
    // pins pass three flops, a change counts once stages two and three agree
    always_comb begin
        next_f      = (s2 & s3) | (f & (s2 ^ s3)) | (~s2 & ~s3 & 23'h000000);
        strobe_rise = f[STB] && !f_q[STB];
        go          = f[GO];
        clr         = rst || !f[MC];
        next_cfg    = config_word;
        if (strobe_rise) begin
            next_cfg = f[15:`A429C_CFG_BUS_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1          <= SYNC_RST;
            s2          <= SYNC_RST;
            s3          <= SYNC_RST;
            f           <= SYNC_RST;
            f_q         <= SYNC_RST;
            config_word <= `A429C_CFG_RESET;
        end else begin
            s1          <= {rx_line_b, rx_line_a, transmit_go, config_strobe,
                            master_clear_n, host_bus_line};
            s2          <= s1;
            s3          <= s2;
            f           <= next_f;
            f_q         <= f;
            config_word <= next_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [30:0]     fifo_data;
    logic            fifo_valid, fifo_empty, pop, tick, half, bit_clk;
    a429c_tx_state_t st, next_st;
    logic [31:0]     shift, next_shift, word32;
    logic [5:0]      bits, next_bits;
    logic [2:0]      gap, next_gap;
    logic            trate, next_trate, tlen, next_tlen, tpar, next_tpar;
    logic            par, next_hi, next_lo;
    // words are taken only while transmit go was low one cycle earlier
    a429c_fifo #(.W(31), .D(DEPTH), .AW($clog2(DEPTH))) a429c_fifo_inst (
        .clk       (clk),
        .clr       (clr),
        .hold      (go),
        .in_data   (tx_word_data),
        .in_valid  (tx_word_valid),
        .in_ready  (tx_word_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .empty     (fifo_empty)
    );
    a429c_rate_div #(.FAST(`A429C_DIV_FAST), .SLOW(`A429C_DIV_SLOW), .CW(7)) a429c_rate_div_inst (
        .clk     (clk),
        .clr     (clr),
        .slow    (trate),
        .tick    (tick),
        .half    (half),
        .clk_out (bit_clk)
    );
    always_comb begin
        next_st    = st;
        next_shift = shift;
        next_bits  = bits;
        next_gap   = gap;
        next_trate = trate;
        next_tlen  = tlen;
        next_tpar  = tpar;
        next_hi    = line_out_hi;
        next_lo    = line_out_lo;
        pop        = 1'b0;
        par        = 1'b0;
        word32     = '0;
        case (st)
            TX_IDLE: begin
                next_trate = config_word[`A429C_F_TX_RATE];
                next_tlen  = config_word[`A429C_F_LEN];
                next_tpar  = config_word[`A429C_F_PAR_FLIP];
                if (config_word[`A429C_F_LEN]) begin
                    par    = ~^fifo_data[23:0] ^ config_word[`A429C_F_PAR_FLIP];
                    word32 = {7'h00, par, fifo_data[23:0]};
                end else begin
                    par    = ~^fifo_data ^ config_word[`A429C_F_PAR_FLIP];
                    word32 = {par, fifo_data};
                end
                if (go && fifo_valid && tick) begin
                    pop        = 1'b1;
                    next_shift = word32;
                    next_bits  = 6'h01;
                    next_hi    = word32[0];
                    next_lo    = !word32[0];
                    next_st    = TX_BITS;
                end
            end
            TX_BITS: begin
                if (half) begin
                    next_hi = 1'b0;
                    next_lo = 1'b0;
                end
                if (tick) begin
                    if (bits == (tlen ? LEN_S : LEN_L)) begin
                        next_gap = 3'h1;
                        next_st  = TX_GAP;
                    end else begin
                        next_hi   = shift[bits[4:0]];
                        next_lo   = !shift[bits[4:0]];
                        next_bits = bits + 6'h01;
                    end
                end
            end
            TX_GAP: begin
                if (tick) begin
                    next_gap = gap + 3'h1;
                    if (gap == GAP_END) begin
                        next_st = TX_IDLE;
                    end
                end
            end
            default: next_st = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            st                 <= TX_IDLE;
            shift              <= '0;
            bits               <= '0;
            gap                <= '0;
            trate              <= 1'b0;
            tlen               <= 1'b0;
            tpar               <= 1'b0;
            line_out_hi        <= 1'b0;
            line_out_lo        <= 1'b0;
            send_bit_clock_out <= 1'b0;
            tx_empty           <= 1'b1;
        end else begin
            st                 <= next_st;
            shift              <= next_shift;
            bits               <= next_bits;
            gap                <= next_gap;
            trate              <= next_trate;
            tlen               <= next_tlen;
            tpar               <= next_tpar;
            line_out_hi        <= next_hi;
            line_out_lo        <= next_lo;
            send_bit_clock_out <= bit_clk;
            tx_empty           <= fifo_empty;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] rword [2];
    logic [1:0]  rrdy;
    logic        self_test;
    assign self_test = !config_word[`A429C_F_SELFTEST_N];
    for (genvar g = 0; g < 2; g++) begin : g_rx
        logic             in_a, in_b, act_q, en, hit;
        logic             rlen, next_rlen, rrate, next_rrate, next_rdy;
        logic [31:0]      rsh, next_rsh, next_word;
        logic [5:0]       rcnt, next_rcnt;
        logic [TMO_W-1:0] rtim, next_rtim;
        always_comb begin
            // true data to receiver one, inverted to receiver two
            in_a = self_test ? (g == 0 ? line_out_hi : line_out_lo) : f[RXA+g];
            in_b = self_test ? (g == 0 ? line_out_lo : line_out_hi) : f[RXB+g];
            en   = config_word[`A429C_F_R1_EN + 3*g];
            hit  = (config_word[`A429C_F_R1_A + 3*g] == rsh[8])
                && (config_word[`A429C_F_R1_B + 3*g] == rsh[9]);
            next_rlen  = rlen;
            next_rrate = rrate;
            next_rsh   = rsh;
            next_rcnt  = rcnt;
            next_rtim  = rtim;
            next_word  = rword[g];
            next_rdy   = 1'b0;
            if ((in_a || in_b) && !act_q) begin
                if (rcnt == '0) begin
                    next_rlen  = config_word[`A429C_F_LEN];
                    next_rrate = config_word[`A429C_F_RX_RATE];
                    next_rsh   = '0;
                end
                next_rsh[rcnt[4:0]] = in_a;
                next_rcnt = rcnt + 6'h01;
                next_rtim = '0;
            end else if (rcnt == (rlen ? LEN_S : LEN_L)) begin
                next_rcnt = '0;
                if (!en || hit) begin
                    next_word = rsh;
                    next_rdy  = 1'b1;
                end
            end else if (rcnt != '0) begin
                next_rtim = rtim + 1'b1;
                if (rtim >= (rrate ? TMO_S : TMO_F)) begin
                    next_rcnt = '0;
                end
            end
        end

        always_ff @(posedge clk) begin
            if (clr) begin
                act_q    <= 1'b0;
                rlen     <= 1'b0;
                rrate    <= 1'b0;
                rsh      <= '0;
                rcnt     <= '0;
                rtim     <= '0;
                rword[g] <= '0;
                rrdy[g]  <= 1'b0;
            end else begin
                act_q    <= in_a || in_b;
                rlen     <= next_rlen;
                rrate    <= next_rrate;
                rsh      <= next_rsh;
                rcnt     <= next_rcnt;
                rtim     <= next_rtim;
                rword[g] <= next_word;
                rrdy[g]  <= next_rdy;
            end
        end
    end

    assign rcv1_word  = rword[0];
    assign rcv1_ready = rrdy[0];
    assign rcv2_word  = rword[1];
    assign rcv2_ready = rrdy[1];

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence word_start;
        pop ##1 (st == TX_BITS);
    endsequence

    cfg_capture_a: assert property (strobe_rise |=> config_word == $past(f[15:5]))
        else $error("config word not captured");
    cfg_hold_a: assert property (!strobe_rise |=> $stable(config_word))
        else $error("config word changed without strobe");
    fast_rate_a: assert property ((st == TX_BITS) && tick && !trate |-> ##10 tick)
        else $error("fast bit period wrong");
    slow_rate_a: assert property ((st == TX_BITS) && tick && trate |-> ##80 tick)
        else $error("slow bit period wrong");
    bit_clock_a: assert property (tick |=> send_bit_clock_out)
        else $error("bit clock low at bit start");
    empty_flag_a: assert property (fifo_empty |=> tx_empty)
        else $error("empty flag missing");
    go_gate_a: assert property (pop |-> go)
        else $error("word sent without transmit go");
    clear_tx_a: assert property (!f[MC] |=> (st == TX_IDLE) && !line_out_hi && !line_out_lo)
        else $error("master clear left transmitter busy");
    loop_drive_a: assert property (word_start and (self_test ##1 1'b1)
        |-> (line_out_hi || line_out_lo))
        else $error("line idle during loopback");
    parity_a: assert property (word_start |-> (^shift[24:0] == !tpar) || !tlen)
        else $error("short word parity wrong");
    filter_a: assert property (rrdy[0] |-> !$past(config_word[1])
        || (rword[0][9:8] == $past(config_word[3:2])))
        else $error("filtered word accepted");
    settings_a: assert property ((st != TX_IDLE) |=> $stable(trate) && $stable(tlen))
        else $error("settings changed mid word");

endmodule : a429c_top

// file: tb/a429c_host.sv
/*
 * Host processor model: control word strobe and transmit word stream.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/1ns
module a429c_host (
    // clock
    input  wire logic   clk,
    // control word pins
    output logic        config_strobe,
    output logic [15:0] host_bus_line,
    // transmit word stream
    output logic [30:0] tx_word_data,
    output logic        tx_word_valid,
    input  wire logic   tx_word_ready
);
    initial begin
        config_strobe = 1'b0;
        host_bus_line = 16'hFFFF;
        tx_word_data  = 31'h0;
        tx_word_valid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // bus held from one cycle before strobe rises until strobe falls
    task automatic write_cfg(input logic [15:0] v);
        host_bus_line <= v;
        @(posedge clk);
        config_strobe <= 1'b1;
        repeat (5) @(posedge clk);
        config_strobe <= 1'b0;
        host_bus_line <= ~v;
        repeat (4) @(posedge clk);
    endtask : write_cfg

    ////////////////////////////////////////////////////////////////////
    // label sits in bit 0, sent first
    task automatic push(input logic [30:0] d, input int gap, output logic ok);
        int n;
        repeat (gap) @(posedge clk);
        tx_word_data  <= d;
        tx_word_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tx_word_ready !== 1'b1 && n < 40);
        ok = (tx_word_ready === 1'b1);
        tx_word_valid <= 1'b0;
        tx_word_data  <= ~d;
    endtask : push
endmodule : a429c_host

// file: tb/a429c_top_test.sv
/*
 * Self-checking bench of the control block, transmitter looped back except in t_line.
 * Assumes the host model drives the strobe, bus and word stream.
 */
`timescale 1ns/1ns
module a429c_top_test
    import a429c_pkg::*;
;
    logic        clk, rst, master_clear_n, transmit_go;
    logic [1:0]  rx_line_a, rx_line_b;
    logic        config_strobe, tx_word_valid, tx_word_ready;
    logic [15:0] host_bus_line;
    logic [30:0] tx_word_data;
    logic        line_out_hi, line_out_lo, send_bit_clock_out, tx_empty;
    a429c_cfg_t  config_word;
    logic [31:0] rcv1_word, rcv2_word;
    logic        rcv1_ready, rcv2_ready;
    int          n_errors = 0;
    int          checks = 0;

    a429c_host a429c_host_inst (.clk(clk), .config_strobe(config_strobe),
        .host_bus_line(host_bus_line), .tx_word_data(tx_word_data),
        .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready));
    a429c_top a429c_top_inst (.clk(clk), .rst(rst), .master_clear_n(master_clear_n),
        .config_strobe(config_strobe), .transmit_go(transmit_go),
        .host_bus_line(host_bus_line), .tx_word_data(tx_word_data),
        .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready),
        .rx_line_a(rx_line_a), .rx_line_b(rx_line_b), .line_out_hi(line_out_hi),
        .line_out_lo(line_out_lo), .send_bit_clock_out(send_bit_clock_out),
        .tx_empty(tx_empty), .config_word(config_word), .rcv1_word(rcv1_word),
        .rcv1_ready(rcv1_ready), .rcv2_word(rcv2_word), .rcv2_ready(rcv2_ready));

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check_v(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_v

    task automatic check_b(input logic got, input logic exp);
        check_v({31'h0, got}, {31'h0, exp});
    endtask : check_b

    task automatic results();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // fixed span long enough for one looped-back word at the fast rate
    task automatic wait_rx(output logic g1, output logic g2);
        g1 = 1'b0;
        g2 = 1'b0;
        repeat (700) begin
            @(posedge clk);
            if (rcv1_ready === 1'b1) g1 = 1'b1;
            if (rcv2_ready === 1'b1) g2 = 1'b1;
        end
    endtask : wait_rx

    ////////////////////////////////////////////////////////////////////
    task automatic t_loop(input logic [10:0] cfg, input logic [30:0] d, input logic f1);
        logic ok, g1, g2, p;
        logic [31:0] w;
        a429c_host_inst.write_cfg({cfg, 5'h1F});
        check_v(32'(config_word), 32'(cfg));
        a429c_host_inst.push(d, 3, ok);
        repeat (3) @(posedge clk);
        check_b(tx_empty, 1'b0);
        transmit_go <= 1'b1;
        wait_rx(g1, g2);
        transmit_go <= 1'b0;
        p = cfg[7] ^ ~(^d);
        w = {p, d};
        if (cfg[10]) w = {7'h00, cfg[7] ^ ~(^d[23:0]), d[23:0]};
        check_b(g1, f1);
        check_b(g2, 1'b1);
        if (f1) check_v(rcv1_word, w);
        check_v(rcv2_word, cfg[10] ? {7'h00, ~w[24:0]} : ~w);
        check_b(tx_empty, 1'b1);
    endtask : t_loop

    task automatic t_rate(input logic [10:0] cfg, input int exp);
        logic q;
        int   k, a, b;
        a429c_host_inst.write_cfg({cfg, 5'h00});
        a = -1;
        b = -1;
        q = send_bit_clock_out;
        for (k = 0; k < 400; k++) begin
            @(posedge clk);
            if (send_bit_clock_out === 1'b1 && q !== 1'b1) begin
                if (a < 0) a = k;
                else if (b < 0) b = k;
            end
            q = send_bit_clock_out;
        end
        check_v(32'(b - a), 32'(exp));
    endtask : t_rate

    task automatic t_clear();
        logic ok;
        a429c_host_inst.write_cfg(16'h1000);
        a429c_host_inst.push(31'h1234567, 1, ok);
        repeat (3) @(posedge clk);
        check_b(tx_empty, 1'b0);
        master_clear_n <= 1'b0;
        repeat (6) @(posedge clk);
        master_clear_n <= 1'b1;
        repeat (6) @(posedge clk);
        check_b(tx_empty, 1'b1);
        check_v(32'(config_word), 32'h080);
    endtask : t_clear

    task automatic t_fill();
        logic ok, g1, g2;
        int   n, i;
        a429c_host_inst.write_cfg(16'h0000);
        n = 0;
        for (i = 0; i < 9; i++) begin
            a429c_host_inst.push(31'(i * 3 + 1), 1, ok);
            if (ok) n++;
        end
        check_v(32'(n), 32'h8);
        transmit_go <= 1'b1;
        n = 0;
        while (tx_empty !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        check_b(tx_empty, 1'b1);
        transmit_go <= 1'b0;
        wait_rx(g1, g2);
        check_v(rcv1_word, {~(^31'h16), 31'h16});
    endtask : t_fill

    // serial word on both receiver pins, self test off
    task automatic t_line(input logic [31:0] w);
        int i;
        a429c_host_inst.write_cfg(16'h0020);
        for (i = 0; i < 32; i++) begin
            rx_line_a <= {2{w[i]}};
            rx_line_b <= {2{~w[i]}};
            repeat (5) @(posedge clk);
            rx_line_a <= 2'h0;
            rx_line_b <= 2'h0;
            repeat (5) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        check_v(rcv1_word, w);
        check_v(rcv2_word, w);
    endtask : t_line

    ////////////////////////////////////////////////////////////////////
    initial begin
        #160000;
        n_errors++;
        results();
    end

    initial begin
        rst = 1'b1;
        master_clear_n = 1'b1;
        transmit_go = 1'b0;
        rx_line_a = 2'h0;
        rx_line_b = 2'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check_v(32'(config_word), 32'h001);
        check_b(tx_empty, 1'b1);
        t_loop(11'h000, 31'h1234_5678, 1'b1);
        t_loop(11'h080, 31'h1234_5678, 1'b1);
        t_loop(11'h07E, 31'h7000_0C5A, 1'b0);
        t_loop(11'h480, 31'h0123_4567, 1'b1);
        t_rate(11'h000, 10);
        t_rate(11'h100, 80);
        t_clear();
        t_fill();
        t_line(32'hA5C3_1E96);
        results();
    end
endmodule : a429c_top_test
